/* core/wss_pkg.sv */
// Package of offsets, fields and codes for the second wake source selector
package wss_pkg;
  // Register byte addresses on APB (printed offset 0xd is not a multiple of four: index*4)
  localparam logic [7:0] WSS_IDX_SECOND   = 8'h0d;
  localparam logic [7:0] WSS_IDX_PRIMARY  = 8'h0b;
  localparam logic [7:0] WSS_IDX_PORTDIR  = 8'h10;
  localparam logic [7:0] WSS_IDX_STATUS   = 8'h11;
  localparam logic [9:0] WSS_ADDR_SECOND  = {WSS_IDX_SECOND, 2'b00};
  localparam logic [9:0] WSS_ADDR_PRIMARY = {WSS_IDX_PRIMARY, 2'b00};
  localparam logic [9:0] WSS_ADDR_PORTDIR = {WSS_IDX_PORTDIR, 2'b00};
  localparam logic [9:0] WSS_ADDR_STATUS  = {WSS_IDX_STATUS, 2'b00};
  // Field positions in the selector registers
  localparam int WSS_SRC_LSB   = 2;
  localparam int WSS_SRC_MSB   = 4;
  localparam int WSS_DELAY_BIT = 5;
  localparam int WSS_LEVEL_BIT = 6;
  // Reset values
  localparam logic [2:0] WSS_SRC_RST   = 3'h0;
  localparam logic       WSS_LEVEL_RST = 1'b0;
  localparam logic       WSS_DELAY_RST = 1'b1;
  localparam logic [23:0] WSS_DIR_RST  = 24'h00_0000;
  // Timing: post-wake delay stands in for the power-on delay
  localparam int WSS_CLK_NS       = 50;
  localparam int WSS_POR_DELAY_US = 2500;
  localparam int WSS_POR_CYCLES   = (WSS_POR_DELAY_US * 1000) / WSS_CLK_NS;
  // Source codes
  typedef enum logic [2:0] {
    WSS_POR_ONLY, WSS_NAND_P2LO, WSS_NAND_P2ALL, WSS_NOR_P3,
    WSS_NAND_P3, WSS_NOR_P3P0, WSS_NAND_P3P0, WSS_NAND_P3P2
  } wss_src_t;
endpackage

/* core/wss_top.sv */
// Second stop-recovery source selector with primary selector and APB slave
// Function
// - code 111 NANDs port3 1-3, port2 0-2
// - level bit picks low or high wake
// - either selector's wake event exits halt
// - output-configured port lines excluded from function
// - source and level bits are write-only
// - codes 001-110 select documented line groups, 000 selects none
// - primary delay bit inserts power-on delay
`timescale 1ns/1ns
`default_nettype none
module wss_top
  import wss_pkg::*;
#(
  parameter int POR_CYCLES = WSS_POR_CYCLES
) (
  input  wire logic        pclk,        // System clock, 20 MHz
  input  wire logic        presetn,     // Async reset, active low
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB access phase
  input  wire logic        pwrite,      // APB write
  input  wire logic [11:0] paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  input  wire logic        halted,      // Core is in stop mode
  input  wire logic [7:0]  port0_in,    // Port 0 input levels
  input  wire logic [7:0]  port2_in,    // Port 2 input levels
  input  wire logic [7:0]  port3_in,    // Port 3 input levels
  output logic             wake,        // Leave stop mode, pulse
  output logic             wake_flag    // Sticky recovery happened
);
  import wss_pkg::*;

  // Stored selector fields; both selectors share one layout
  logic [2:0]  src2, src1;
  logic        lvl2, lvl1, dly;
  logic [23:0] dir;            // 1 = line is an output: {port3, port2, port0}
  logic        waiting;
  logic [31:0] cnt;

  // Gated NAND/NOR over selected lines; outputs drop out of the term
  function automatic logic gate_fn(input logic [23:0] v, input logic [23:0] sel,
                                   input logic is_nor);
    logic [23:0] m;
    m = sel;
    if (is_nor) gate_fn = ~|(v & m);
    else        gate_fn = ~&(v | ~m);
  endfunction

  // Line masks per source code, positions {p3, p2, p0}
  function automatic logic wake_fn(input logic [2:0] code, input logic [23:0] v,
                                   input logic [23:0] d, input logic level);
    logic [23:0] sel;
    logic        isnor, f;
    sel = 24'h00_0000;
    isnor = 1'b0;
    unique case (wss_src_t'(code))
      WSS_POR_ONLY:   sel = 24'h00_0000;
      WSS_NAND_P2LO:  sel = 24'h00_0f00;
      WSS_NAND_P2ALL: sel = 24'h00_ff00;
      WSS_NOR_P3:     begin sel = 24'h0e_0000; isnor = 1'b1; end
      WSS_NAND_P3:    sel = 24'h0e_0000;
      WSS_NOR_P3P0:   begin sel = 24'h0e_0081; isnor = 1'b1; end
      WSS_NAND_P3P0:  sel = 24'h0e_0081;
      WSS_NAND_P3P2:  sel = 24'h0e_0700;
    endcase
    sel = sel & ~d;
    f = gate_fn(v, sel, isnor);
    // No live line means no wake event at all
    wake_fn = (sel != 24'h00_0000) && !(f ^ level);
  endfunction

  // APB decode; slave always ready in the access cycle
  // Selector reads give zero so write-only fields stay hidden
  wire wr_en   = psel && penable && pwrite;
  wire [9:0] word = paddr[11:2];
  wire hit     = (word == WSS_ADDR_SECOND[9:0] >> 2) || (word == WSS_ADDR_PRIMARY[9:0] >> 2)
              || (word == WSS_ADDR_PORTDIR[9:0] >> 2) || (word == WSS_ADDR_STATUS[9:0] >> 2);
  wire [23:0] pins = {port3_in, port2_in, port0_in};
  wire ev2 = wake_fn(src2, pins, dir, lvl2);
  wire ev1 = wake_fn(src1, pins, dir, lvl1);
  wire event_any = halted && (ev1 || ev2);
  wire [31:0] next_prdata = (word == WSS_ADDR_STATUS[9:0] >> 2) ?
                            {30'h0000_0000, waiting, wake_flag} :
                            (word == WSS_ADDR_PORTDIR[9:0] >> 2) ? {8'h00, dir} : 32'h0000_0000;

  // Register writes; reserved bits are simply not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src2 <= WSS_SRC_RST;
      lvl2 <= WSS_LEVEL_RST;
      src1 <= WSS_SRC_RST;
      lvl1 <= WSS_LEVEL_RST;
      dly  <= WSS_DELAY_RST;
      dir  <= WSS_DIR_RST;
    end else if (wr_en) begin
      if (word == WSS_ADDR_SECOND[9:0] >> 2) begin
        src2 <= pwdata[WSS_SRC_MSB:WSS_SRC_LSB];
        lvl2 <= pwdata[WSS_LEVEL_BIT];
      end
      if (word == WSS_ADDR_PRIMARY[9:0] >> 2) begin
        src1 <= pwdata[WSS_SRC_MSB:WSS_SRC_LSB];
        lvl1 <= pwdata[WSS_LEVEL_BIT];
        dly  <= pwdata[WSS_DELAY_BIT];
      end
      if (word == WSS_ADDR_PORTDIR[9:0] >> 2) dir <= pwdata[23:0];
    end
  end

  // Bus answer: one wait-free access phase, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= next_prdata;
    end
  end

  // Wake sequencing: optional post-wake delay, then a one-cycle pulse
  // A line held active re-arms after each pulse and wakes again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waiting   <= 1'b0;
      cnt       <= 32'h0000_0000;
      wake      <= 1'b0;
      wake_flag <= 1'b0;
    end else begin
      wake <= 1'b0;
      if (waiting) begin
        if (cnt == 32'h0000_0000) begin
          waiting <= 1'b0;
          wake    <= 1'b1;
        end else begin
          cnt <= cnt - 32'h0000_0001;
        end
      end else if (event_any && !wake) begin
        wake_flag <= 1'b1;
        if (dly) begin
          waiting <= 1'b1;
          cnt     <= 32'(POR_CYCLES - 1);
        end else begin
          wake <= 1'b1;
        end
      end
    end
  end

  // Event with no delay selected wakes on the next edge
  property p_fast_wake;
    @(posedge pclk) disable iff (!presetn)
      (event_any && !dly && !waiting && !wake) |=> wake;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("wake missing after event");

  // Delayed wake stays low for the first two cycles of the wait
  property p_delay_hold;
    @(posedge pclk) disable iff (!presetn)
      $rose(waiting) |-> !wake [*2];
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("wake fired during delay");

  // Code 111 with all six lines high and level low must raise an event
  property p_code7;
    @(posedge pclk) disable iff (!presetn)
      (halted && src2 == 3'h7 && !lvl2 && dir == 24'h00_0000 && &port3_in[3:1]
       && &port2_in[2:0]) |-> ev2;
  endproperty
  a_code7: assert property (p_code7) else $error("code 7 nand not detected");

  // Output lines never contribute
  property p_excluded;
    @(posedge pclk) disable iff (!presetn)
      (src2 == 3'h1 && dir[11:8] == 4'hf) |-> !ev2;
  endproperty
  a_excluded: assert property (p_excluded) else $error("output line used as source");

  // Selector reads return no stored fields
  property p_wo;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && word == WSS_ADDR_SECOND[9:0] >> 2) |=> prdata == 32'h0000_0000;
  endproperty
  a_wo: assert property (p_wo) else $error("write-only field read back");

  // Power-on-only codes on both selectors never make an event
  property p_por_only;
    @(posedge pclk) disable iff (!presetn)
      (src1 == 3'h0 && src2 == 3'h0) |-> !event_any;
  endproperty
  a_por_only: assert property (p_por_only) else $error("event with no source");

  // NAND of port3 lines with a low line wakes at high level
  property p_nand_high;
    @(posedge pclk) disable iff (!presetn)
      (src2 == 3'h4 && lvl2 && dir == 24'h00_0000 && !(&port3_in[3:1])) |-> ev2;
  endproperty
  a_nand_high: assert property (p_nand_high) else $error("nand event missed");

  // NOR of all-low port3 lines matches only a high level
  property p_nor_level;
    @(posedge pclk) disable iff (!presetn)
      (src2 == 3'h3 && dir == 24'h00_0000 && port3_in[3:1] == 3'b000) |-> (ev2 == lvl2);
  endproperty
  a_nor_level: assert property (p_nor_level) else $error("nor event wrong");

  // Delay selected: enter the wait, no immediate pulse
  property p_delay_start;
    @(posedge pclk) disable iff (!presetn)
      (event_any && dly && !waiting && !wake) |=> (waiting && !wake);
  endproperty
  a_delay_start: assert property (p_delay_start) else $error("delayed wake wrong");
endmodule // wss_top
`default_nettype wire

/* verif/wss_keys.sv */
// Model of the key and port lines seen by the wake selector
`timescale 1ns/1ns
`default_nettype none
module wss_keys (
  input  wire logic        pclk,     // System clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        press,    // Bench asks for a key press
  input  wire logic [23:0] mask,     // Lines pulled low, {port3,port2,port0}
  output logic      [7:0]  port0_in, // Port 0 levels
  output logic      [7:0]  port2_in, // Port 2 levels
  output logic      [7:0]  port3_in  // Port 3 levels
);
  logic [3:0] held;
  logic       active;
  // A press stays on the lines at least ten clock periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) held <= 4'h0;
    else if (press) held <= 4'ha;
    else if (held != 4'h0) held <= held - 4'h1;
  end
  // Pull-ups hold released lines high
  assign active = press | (held != 4'h0);
  assign {port3_in, port2_in, port0_in} = active ? ~mask : 24'hff_ffff;
endmodule // wss_keys
`default_nettype wire

/* verif/stop_recovery_source_select_2_test.sv */
// Self-checking bench for the second wake source selector
`timescale 1ns/1ns
`default_nettype none
module stop_recovery_source_select_2_test;
  import wss_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        halted = 0, press = 0, pready, pslverr, wake, wake_flag, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [23:0] mask = 24'h00_0000, m [8];
  logic [7:0]  p0, p2, p3;
  localparam logic [11:0] adr_second  = {2'b00, WSS_ADDR_SECOND};
  localparam logic [11:0] adr_primary = {2'b00, WSS_ADDR_PRIMARY};
  localparam logic [11:0] adr_dir     = {2'b00, WSS_ADDR_PORTDIR};
  localparam logic [11:0] adr_status  = {2'b00, WSS_ADDR_STATUS};
  int          err_total = 0, checks_done = 0, n;
  always #25 pclk = ~pclk;
  wss_top #(.POR_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halted(halted), .port0_in(p0), .port2_in(p2),
    .port3_in(p3), .wake(wake), .wake_flag(wake_flag));
  wss_keys i_keys (.pclk(pclk), .presetn(presetn), .press(press), .mask(mask),
    .port0_in(p0), .port2_in(p2), .port3_in(p3));
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  // One APB transfer, held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Press lines, count cycles to wake (30 means none), then let lines settle
  task press_wait(input logic [23:0] k);
    @(posedge pclk);
    mask <= k;
    press <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (wake !== 1'b1 && n < 30);
    press <= 1'b0;
    repeat (14) @(posedge pclk);
  endtask
  task t_regs;
    apb(1'b0, adr_second, 32'h0000_0000);
    chk("second_read", 0, rd);
    apb(1'b0, 12'h0f0, 32'h0000_0000);
    chk("unmapped_err", 1, {31'h0, er});
  endtask
  task t_codes;
    m = '{24'h00_0100, 24'h00_0100, 24'h00_8000, 24'h0e_0000,
          24'h02_0000, 24'h0e_0081, 24'h00_0080, 24'h00_0400};
    apb(1'b1, adr_primary, 32'h0000_0000); // Primary idle, no delay
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, adr_second, 32'h40 | (i << 2));
      press_wait(m[i]);
      chk("code_wake", (i == 0) ? 1 : 0, {31'h0, n == 30});
    end
    chk("wake_flag", 1, {31'h0, wake_flag});
  endtask
  task t_outdir;
    apb(1'b1, adr_dir, 32'h0000_0100);
    apb(1'b0, adr_dir, 32'h0000_0000);
    chk("dir_readback", 32'h0000_0100, rd);
    apb(1'b1, adr_second, 32'h44);
    press_wait(24'h00_0100);
    chk("out_line_ignored", 30, n);
    press_wait(24'h00_0200);
    chk("in_line_wakes", 1, {31'h0, n <= 3});
    apb(1'b1, adr_dir, 32'h0000_0f00);
    press_wait(24'h00_0f00);
    chk("all_out_idle", 30, n);
    apb(1'b1, adr_dir, 32'h0000_0000);
  endtask
  task t_level;
    apb(1'b1, adr_second, 32'h0c);
    press_wait(24'h00_0000);
    chk("low_level_wake", 1, {31'h0, n <= 3});
    apb(1'b1, adr_second, 32'h1c);
    press_wait(24'h00_0000);
    chk("code7_low_wake", 1, {31'h0, n <= 3});
    apb(1'b1, adr_second, 32'h4c);
    press_wait(24'h00_0000);
    chk("high_level_idle", 30, n);
  endtask
  task t_both;
    apb(1'b1, adr_second, 32'h44);
    apb(1'b1, adr_primary, 32'h50);
    press_wait(24'h00_0100);
    chk("second_event", 1, {31'h0, n <= 3});
    press_wait(24'h02_0000);
    chk("primary_event", 1, {31'h0, n <= 3});
    apb(1'b1, adr_primary, 32'h70);
    press_wait(24'h02_0000);
    chk("delayed_wake", 1, {31'h0, n >= 9 && n <= 12});
    apb(1'b0, adr_status, 32'h0000_0000);
    chk("status_flag", 1, {31'h0, rd[0]});
  endtask
  task final_report;
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run needs about 500 cycles
  initial begin
    #500_000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    halted <= 1'b1;
    t_regs;
    t_codes;
    t_outdir;
    t_level;
    t_both;
    final_report;
  end
endmodule // stop_recovery_source_select_2_test
`default_nettype wire
